// ==== src/i2c_srst_cfg.sv ====
// The implementer's own choice: the APB slave port.
`include "i2c_srst_regs.svh"

module i2c_srst_cfg #(
  parameter int QTR = `QTR_CYC,
  parameter int IDLE = `IDLE_CYC
) (
  // Clock and reset.
  input wire logic MCLK_I,
  input wire logic RST_N_I,
  // APB slave.
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [19:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  // Two-wire bus, open drain.
  input wire logic SCL_I,
  output logic SCL_O,
  output logic SCL_OE_O,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE_O,
  // Power-up strap.
  input wire logic [6:0] STRAP_ADDR_I
);
  import i2c_srst_pkg::*;

  logic soft_reset_hold, next_srst;
  logic byte_order, next_order, mst_write, next_write;
  logic [1:0] pa_len, next_pa_len;
  logic [6:0] dev_addr, next_dev;
  logic [2:0] mst_size, next_size;
  logic [15:0] mst_paddr, next_paddr;
  logic [31:0] tx_data, next_tx, rx_data, next_rx;
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr;
  mst_state_t state, next_state, after_pa;
  logic issued, next_issued, start, next_start;
  logic ev_done, next_ev_done, ev_nack, next_ev_nack;
  logic [2:0] cnt, next_cnt, n_bytes;
  logic [1:0] pa_n, lane;
  logic [15:0] idle_cnt, next_idle_cnt;
  logic bus_idle, next_bus_idle;
  logic [6:0] strap, next_strap;
  logic strap_done, next_strap_done;
  logic wr, setup, cmd_valid, eng_done, eng_ack;
  logic [7:0] eng_tx, eng_rx;
  line_cmd_t eng_cmd;

  assign wr = PSEL_I && PENABLE_I && PWRITE_I && PREADY_O;
  assign setup = PSEL_I && !PENABLE_I;
  assign n_bytes = (mst_size > `MAX_BYTES) ? 3'h0 : mst_size;
  assign pa_n = (pa_len == `PAL_ONE || pa_len == `PAL_TWO) ? pa_len : 2'h0;
  assign lane = byte_order ? cnt[1:0] : 2'(n_bytes - 3'h1 - cnt);
  assign cmd_valid = (state != ST_IDLE) && !issued;

  // Bus answer: zero wait states, data sampled in the setup cycle.
  always_comb begin
    next_pready = setup;
    next_prdata = 32'h0000_0000;
    next_pslverr = 1'b0;
    if (setup) begin
      unique case (PADDR_I)
        `OFS_SOFT_RESET: next_prdata[`BIT_SOFT_RESET] = soft_reset_hold;
        `OFS_MST_CFG: begin
          next_prdata[`BIT_BYTE_ORDER] = byte_order;
          next_prdata[`PAL_HI:`PAL_LO] = pa_len;
          next_prdata[`DEV_HI:0] = dev_addr;
        end
        `OFS_MST_CTRL: begin
          next_prdata[`BIT_START] = start;
          next_prdata[`BIT_WRITE] = mst_write;
          next_prdata[`SIZE_HI:`SIZE_LO] = mst_size;
          next_prdata[`PADDR_HI:0] = mst_paddr;
        end
        `OFS_RX_DATA: next_prdata = rx_data;
        `OFS_TX_DATA: next_prdata = tx_data;
        `OFS_STATUS: begin
          next_prdata[`STS_BUSY] = start;
          next_prdata[`STS_DONE] = ev_done;
          next_prdata[`STS_NACK] = ev_nack;
          next_prdata[`STS_BUS_IDLE] = bus_idle;
          next_prdata[`STS_STRAP_LO +: 7] = strap;
        end
        default: next_pslverr = 1'b1;
      endcase
    end
  end

  // Writable fields; the soft reset never touches them.
  always_comb begin
    next_srst = soft_reset_hold;
    next_order = byte_order;
    next_pa_len = pa_len;
    next_dev = dev_addr;
    next_write = mst_write;
    next_size = mst_size;
    next_paddr = mst_paddr;
    next_tx = tx_data;
    if (wr) begin
      unique case (PADDR_I)
        `OFS_SOFT_RESET: next_srst = PWDATA_I[`BIT_SOFT_RESET];
        `OFS_MST_CFG: begin
          next_order = PWDATA_I[`BIT_BYTE_ORDER];
          next_pa_len = PWDATA_I[`PAL_HI:`PAL_LO];
          next_dev = PWDATA_I[`DEV_HI:0];
        end
        `OFS_MST_CTRL: begin
          next_write = PWDATA_I[`BIT_WRITE];
          next_size = PWDATA_I[`SIZE_HI:`SIZE_LO];
          next_paddr = PWDATA_I[`PADDR_HI:0];
        end
        `OFS_TX_DATA: next_tx = PWDATA_I;
        default: next_srst = soft_reset_hold;
      endcase
    end
  end

  // Transaction sequencer.
  always_comb begin
    next_state = state;
    next_issued = issued;
    next_cnt = cnt;
    next_start = start;
    next_rx = rx_data;
    next_ev_done = ev_done;
    next_ev_nack = ev_nack;
    after_pa = ST_RSTART;
    if (mst_write) begin
      after_pa = (n_bytes != 3'h0) ? ST_DATA : ST_STOP;
    end
    if (cmd_valid) begin
      next_issued = 1'b1;
    end
    // A clear that meets a new event in one cycle loses to the event.
    if (wr && PADDR_I == `OFS_STATUS) begin
      next_ev_done = ev_done && !PWDATA_I[`STS_DONE];
      next_ev_nack = ev_nack && !PWDATA_I[`STS_NACK];
    end
    if (wr && PADDR_I == `OFS_MST_CTRL && PWDATA_I[`BIT_START]) begin
      next_start = 1'b1;
    end
    if (eng_done) begin
      next_issued = 1'b0;
      unique case (state)
        ST_START: next_state = (mst_write || pa_n != 2'h0) ? ST_DEVW : ST_DEVR;
        ST_DEVW: begin
          if (!eng_ack) begin
            next_ev_nack = 1'b1;
            next_state = ST_STOP;
          end else if (pa_n == `PAL_TWO) begin
            next_state = ST_PA_HI;
          end else if (pa_n == `PAL_ONE) begin
            next_state = ST_PA_LO;
          end else begin
            next_state = after_pa;
          end
        end
        ST_PA_HI: next_state = ST_PA_LO;
        ST_PA_LO: next_state = after_pa;
        ST_RSTART: next_state = ST_DEVR;
        ST_DEVR: begin
          next_ev_nack = next_ev_nack || !eng_ack;
          next_state = (eng_ack && n_bytes != 3'h0) ? ST_DATA : ST_STOP;
        end
        ST_DATA: begin
          if (!mst_write) begin
            next_rx[lane*8 +: 8] = eng_rx;
          end
          if (mst_write && !eng_ack) begin
            next_ev_nack = 1'b1;
            next_state = ST_STOP;
          end else if (cnt == n_bytes - 3'h1) begin
            next_state = ST_STOP;
          end else begin
            next_cnt = cnt + 3'h1;
          end
        end
        ST_STOP: begin
          next_state = ST_IDLE;
          next_start = 1'b0;
          next_ev_done = 1'b1;
        end
        ST_IDLE: next_state = ST_IDLE;
      endcase
    end else if (state == ST_IDLE && start && bus_idle) begin
      next_state = ST_START;
      next_cnt = 3'h0;
    end
    if (soft_reset_hold) begin
      next_state = ST_IDLE;
      next_issued = 1'b0;
      next_cnt = 3'h0;
      next_start = 1'b0;
      next_ev_done = 1'b0;
      next_ev_nack = 1'b0;
    end
  end

  always_comb begin
    unique case (state)
      ST_START, ST_RSTART: eng_cmd = CMD_START;
      ST_STOP, ST_IDLE: eng_cmd = CMD_STOP;
      ST_DATA: eng_cmd = mst_write ? CMD_WRITE : CMD_READ;
      default: eng_cmd = CMD_WRITE;
    endcase
    unique case (state)
      ST_DEVW: eng_tx = {dev_addr, 1'b0};
      ST_DEVR: eng_tx = {dev_addr, 1'b1};
      ST_PA_HI: eng_tx = mst_paddr[15:8];
      ST_PA_LO: eng_tx = mst_paddr[7:0];
      default: eng_tx = tx_data[lane*8 +: 8];
    endcase
  end

  // Idle detection reruns after every soft reset; the strap is caught once.
  always_comb begin
    next_idle_cnt = idle_cnt;
    next_bus_idle = bus_idle;
    next_strap = strap;
    next_strap_done = 1'b1;
    if (!strap_done) begin
      next_strap = STRAP_ADDR_I;
    end
    if (soft_reset_hold) begin
      next_idle_cnt = 16'h0000;
      next_bus_idle = 1'b0;
    end else if (!bus_idle) begin
      if (SCL_I && SDA_I) begin
        next_idle_cnt = idle_cnt + 16'h0001;
        next_bus_idle = (idle_cnt == 16'(IDLE - 1));
      end else begin
        next_idle_cnt = 16'h0000;
      end
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      soft_reset_hold <= 1'(`RST_WORD >> `BIT_SOFT_RESET);
      byte_order <= 1'b0;
      pa_len <= `RST_PAL;
      dev_addr <= `RST_DEV;
      mst_write <= 1'b0;
      mst_size <= 3'h0;
      mst_paddr <= 16'h0000;
      tx_data <= `RST_WORD;
      rx_data <= `RST_WORD;
      PRDATA_O <= `RST_WORD;
      PREADY_O <= 1'b0;
      PSLVERR_O <= 1'b0;
      state <= ST_IDLE;
      issued <= 1'b0;
      cnt <= 3'h0;
      start <= 1'b0;
      ev_done <= 1'b0;
      ev_nack <= 1'b0;
      idle_cnt <= 16'h0000;
      bus_idle <= 1'b0;
      strap <= 7'h00;
      strap_done <= 1'b0;
      SCL_O <= 1'b0;
      SDA_O <= 1'b0;
    end else begin
      soft_reset_hold <= next_srst;
      byte_order <= next_order;
      pa_len <= next_pa_len;
      dev_addr <= next_dev;
      mst_write <= next_write;
      mst_size <= next_size;
      mst_paddr <= next_paddr;
      tx_data <= next_tx;
      rx_data <= next_rx;
      PRDATA_O <= next_prdata;
      PREADY_O <= next_pready;
      PSLVERR_O <= next_pslverr;
      state <= next_state;
      issued <= next_issued;
      cnt <= next_cnt;
      start <= next_start;
      ev_done <= next_ev_done;
      ev_nack <= next_ev_nack;
      idle_cnt <= next_idle_cnt;
      bus_idle <= next_bus_idle;
      strap <= next_strap;
      strap_done <= next_strap_done;
      SCL_O <= 1'b0;
      SDA_O <= 1'b0;
    end
  end

  line_engine #(.QTR(QTR)) u_line (
    .clk_i(MCLK_I),
    .rst_n_i(RST_N_I),
    .abort_i(soft_reset_hold),
    .cmd_valid_i(cmd_valid),
    .cmd_i(eng_cmd),
    .tx_byte_i(eng_tx),
    .ack_out_i(cnt != n_bytes - 3'h1),
    .done_o(eng_done),
    .rx_byte_o(eng_rx),
    .ack_in_o(eng_ack),
    .sda_i(SDA_I),
    .scl_oe_o(SCL_OE_O),
    .sda_oe_o(SDA_OE_O)
  );

  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!RST_N_I);

  property p_srst_fsm;
    soft_reset_hold |=> state == ST_IDLE && !issued;
  endproperty
  a_srst_fsm:
    assert property (p_srst_fsm) else $error("soft reset left sequencer busy");

  property p_srst_lines;
    soft_reset_hold ##1 soft_reset_hold |-> !SCL_OE_O && !SDA_OE_O;
  endproperty
  a_srst_lines:
    assert property (p_srst_lines) else $error("line driven in soft reset");

  property p_cfg_kept;
    soft_reset_hold && !wr |=> $stable(pa_len) && $stable(dev_addr)
      && $stable(byte_order);
  endproperty
  a_cfg_kept:
    assert property (p_cfg_kept) else $error("soft reset changed config");

  property p_events_clear;
    soft_reset_hold |=> !ev_done && !ev_nack;
  endproperty
  a_events_clear:
    assert property (p_events_clear) else $error("event kept in soft reset");

  property p_start_clear;
    start && soft_reset_hold |=> !start;
  endproperty
  a_start_clear:
    assert property (p_start_clear) else $error("start not cleared");

  property p_idle_first;
    state == ST_IDLE ##1 state == ST_START |-> $past(bus_idle);
  endproperty
  a_idle_first:
    assert property (p_idle_first) else $error("start before bus idle");

  property p_strap_kept;
    strap_done |=> $stable(strap);
  endproperty
  a_strap_kept:
    assert property (p_strap_kept) else $error("strap recaptured");

  property p_dev_byte;
    state == ST_DEVW |-> eng_tx == {dev_addr, 1'b0};
  endproperty
  a_dev_byte:
    assert property (p_dev_byte) else $error("wrong target address byte");

  property p_pa_skip;
    pa_len == 2'h3 && state == ST_DEVW ##1 state != ST_DEVW
      |-> state != ST_PA_HI && state != ST_PA_LO;
  endproperty
  a_pa_skip:
    assert property (p_pa_skip) else $error("address sent for length 11");

  property p_order;
    state == ST_DATA && mst_write && byte_order && cnt == 3'h0
      |-> eng_tx == tx_data[7:0];
  endproperty
  a_order:
    assert property (p_order) else $error("byte order wrong");

endmodule : i2c_srst_cfg

// ==== src/i2c_srst_pkg.sv ====
package i2c_srst_pkg;

  typedef enum logic [1:0] {
    CMD_START,
    CMD_STOP,
    CMD_WRITE,
    CMD_READ
  } line_cmd_t;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_START,
    ST_DEVW,
    ST_PA_HI,
    ST_PA_LO,
    ST_RSTART,
    ST_DEVR,
    ST_DATA,
    ST_STOP
  } mst_state_t;

endpackage : i2c_srst_pkg

// ==== src/i2c_srst_regs.svh ====
`ifndef I2C_SRST_REGS_SVH
`define I2C_SRST_REGS_SVH

// Register byte addresses.
`define OFS_SOFT_RESET 20'h49104
`define OFS_MST_CFG 20'h49108
`define OFS_MST_CTRL 20'h4910C
`define OFS_RX_DATA 20'h49110
`define OFS_TX_DATA 20'h49114
`define OFS_STATUS 20'h49118

// Field positions.
`define BIT_SOFT_RESET 31
`define BIT_BYTE_ORDER 23
`define PAL_HI 17
`define PAL_LO 16
`define DEV_HI 6
`define BIT_START 31
`define BIT_WRITE 30
`define SIZE_HI 26
`define SIZE_LO 24
`define PADDR_HI 15
`define STS_BUSY 0
`define STS_DONE 1
`define STS_NACK 2
`define STS_BUS_IDLE 3
`define STS_STRAP_LO 8

// Reset values and encodings.
`define RST_WORD 32'h0000_0000
`define RST_PAL 2'h0
`define RST_DEV 7'h00
`define PAL_ONE 2'h1
`define PAL_TWO 2'h2
`define MAX_BYTES 3'h4

// Timing.
`define CLK_PERIOD_NS 50
`define QTR_NS 2500
`define QTR_CYC ((`QTR_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define IDLE_NS 10000
`define IDLE_CYC ((`IDLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ==== src/line_engine.sv ====
`include "i2c_srst_regs.svh"

module line_engine #(
  parameter int QTR = `QTR_CYC
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Command side.
  input wire logic abort_i,
  input wire logic cmd_valid_i,
  input i2c_srst_pkg::line_cmd_t cmd_i,
  input wire logic [7:0] tx_byte_i,
  input wire logic ack_out_i,
  output logic done_o,
  output logic [7:0] rx_byte_o,
  output logic ack_in_o,
  // Line side.
  input wire logic sda_i,
  output logic scl_oe_o,
  output logic sda_oe_o
);
  import i2c_srst_pkg::*;

  logic busy, next_busy;
  line_cmd_t op, next_op;
  logic [1:0] q, next_q;
  logic [15:0] tick, next_tick;
  logic [3:0] bit_idx, next_bit;
  logic [3:0] last;
  logic [7:0] shreg, next_shreg, next_rx;
  logic samp, next_samp, next_ack_in, next_done;
  logic next_scl_oe, next_sda_oe;

  assign last = (op == CMD_WRITE || op == CMD_READ) ? 4'h8 : 4'h0;

  // Each bit is four quarters; clock stretching by slaves is not honoured.
  always_comb begin
    next_busy = busy;
    next_op = op;
    next_q = q;
    next_tick = tick;
    next_bit = bit_idx;
    next_shreg = shreg;
    next_samp = samp;
    next_ack_in = ack_in_o;
    next_rx = rx_byte_o;
    next_done = 1'b0;
    next_scl_oe = scl_oe_o;
    next_sda_oe = sda_oe_o;
    if (abort_i) begin
      next_busy = 1'b0;
      next_scl_oe = 1'b0;
      next_sda_oe = 1'b0;
    end else if (!busy) begin
      if (cmd_valid_i) begin
        next_busy = 1'b1;
        next_op = cmd_i;
        next_q = 2'h0;
        next_tick = 16'h0000;
        next_bit = 4'h0;
        next_shreg = tx_byte_i;
      end
    end else begin
      unique case (op)
        CMD_START: begin
          next_scl_oe = (q == 2'h0) || (q == 2'h3);
          next_sda_oe = q[1];
        end
        CMD_STOP: begin
          next_scl_oe = (q == 2'h0);
          next_sda_oe = !q[1];
        end
        CMD_WRITE, CMD_READ: begin
          next_scl_oe = (q == 2'h0) || (q == 2'h3);
          if (bit_idx == 4'h8) begin
            next_sda_oe = (op == CMD_READ) && ack_out_i;
          end else begin
            next_sda_oe = (op == CMD_WRITE) && !shreg[7];
          end
        end
      endcase
      if (tick == 16'(QTR - 1)) begin
        next_tick = 16'h0000;
        next_q = q + 2'h1;
        if (q == 2'h2) begin
          next_samp = sda_i;
        end
        if (q == 2'h3) begin
          if (bit_idx == last) begin
            next_busy = 1'b0;
            next_done = 1'b1;
            next_rx = shreg;
          end else begin
            next_bit = bit_idx + 4'h1;
          end
          if (bit_idx == 4'h8) begin
            next_ack_in = !samp;
          end else begin
            next_shreg = {shreg[6:0], samp};
          end
        end
      end else begin
        next_tick = tick + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      busy <= 1'b0;
      op <= CMD_START;
      q <= 2'h0;
      tick <= 16'h0000;
      bit_idx <= 4'h0;
      shreg <= 8'h00;
      samp <= 1'b0;
      ack_in_o <= 1'b0;
      rx_byte_o <= 8'h00;
      done_o <= 1'b0;
      scl_oe_o <= 1'b0;
      sda_oe_o <= 1'b0;
    end else begin
      busy <= next_busy;
      op <= next_op;
      q <= next_q;
      tick <= next_tick;
      bit_idx <= next_bit;
      shreg <= next_shreg;
      samp <= next_samp;
      ack_in_o <= next_ack_in;
      rx_byte_o <= next_rx;
      done_o <= next_done;
      scl_oe_o <= next_scl_oe;
      sda_oe_o <= next_sda_oe;
    end
  end

endmodule : line_engine

// ==== tb/i2c_slave_model.sv ====
module i2c_slave_model #(
  parameter logic [6:0] ADDR = 7'h2A
) (
  // Bus lines.
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_oe_o
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] got[$];
  logic [7:0] sh = 8'h00;
  int bitn = 0;
  logic active = 1'b0;
  logic first = 1'b0;
  logic hit = 1'b0;
  // Bytes returned on reads, in bus order; the bench fills this queue.
  logic [7:0] rsp[$];
  logic [7:0] cur = 8'hFF;
  logic rd_mode = 1'b0;
  logic ackd = 1'b0;

  initial sda_oe_o = 1'b0;

  // A start, repeated or not, restarts the bit count.
  always @(negedge sda_i) if (scl_i === 1'b1) begin
    active = 1'b1;
    first = 1'b1;
    rd_mode = 1'b0;
    bitn = 0;
  end

  // A stop also ends read mode, so an idle bus is never pulled low.
  always @(posedge sda_i) if (scl_i === 1'b1) begin
    active = 1'b0;
    rd_mode = 1'b0;
  end

  always @(posedge scl_i) begin
    if (active && bitn < 8) begin
      sh = {sh[6:0], sda_i};
      bitn++;
    end else if (bitn == 9) begin
      ackd = !sda_i;
    end
  end

  // Acknowledge only a matching address and the bytes written after it.
  always @(negedge scl_i) begin
    if (active && bitn == 8 && rd_mode) begin
      sda_oe_o = 1'b0;
      bitn = 9;
    end else if (active && bitn == 8) begin
      got.push_back(sh);
      if (first) begin
        hit = (sh[7:1] == ADDR);
        rd_mode = hit && sh[0];
      end
      first = 1'b0;
      sda_oe_o = hit;
      bitn = 9;
    end else if (bitn == 9) begin
      cur = (rd_mode && ackd && rsp.size() > 0) ? rsp.pop_front() : 8'hFF;
      sda_oe_o = rd_mode && ackd && !cur[7];
      bitn = 0;
    end else if (active && rd_mode && bitn > 0 && bitn < 8) begin
      sda_oe_o = !cur[7 - bitn];
    end
  end
endmodule : i2c_slave_model

// ==== tb/i2c_soft_reset_master_config_tb.sv ====
`include "i2c_srst_regs.svh"

module i2c_soft_reset_master_config_tb;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [6:0] SLV = 7'h2A;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [19:0] paddr = 20'h00000;
  logic [31:0] pwdata = 32'h00000000;
  logic [6:0] strap = 7'h35;
  logic [31:0] prdata;
  logic pready, pslverr, scl_oe, sda_oe, slv_oe;
  logic scl_o, sda_o, err;
  logic [31:0] rxm = 32'h00000000;
  logic [31:0] rd;
  logic [31:0] seed = 32'h856608C2;
  logic [31:0] c;
  int error_cnt = 0;
  int tests_run = 0;
  int k;
  // Lines are pulled up, so a released line reads high.
  wire logic scl = ~scl_oe;
  wire logic sda = ~(sda_oe | slv_oe);

  always #25 clk = ~clk;

  i2c_srst_cfg #(.QTR(2), .IDLE(4)) dut (
    .MCLK_I(clk), .RST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
    .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
    .SCL_I(scl), .SCL_O(scl_o), .SCL_OE_O(scl_oe), .SDA_I(sda), .SDA_O(sda_o),
    .SDA_OE_O(sda_oe), .STRAP_ADDR_I(strap));

  i2c_slave_model #(.ADDR(SLV)) slv (
    .scl_i(scl), .sda_i(sda), .sda_oe_o(slv_oe));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic fail_wait(input int n, input int lim);
    if (n >= lim) begin
      error_cnt++;
      $display("[ERR] %0t wait limit ran out", $time);
      conclude();
    end
  endtask : fail_wait

  task automatic apb(input logic w, input logic [19:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    fail_wait(n, 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic run_xfer(input logic w, input logic [6:0] dev,
                          input logic [1:0] pal, input logic ord,
                          input int n);
    logic [7:0] q[$];
    logic [31:0] tx;
    logic [15:0] pa;
    int i;
    int ln;
    tx = rnd();
    pa = 16'(rnd() >> 8);
    slv.rsp.delete();
    if (w || pal == 2'h1 || pal == 2'h2) q.push_back({dev, 1'b0});
    if (pal == 2'h2) q.push_back(pa[15:8]);
    if (pal == 2'h1 || pal == 2'h2) q.push_back(pa[7:0]);
    if (!w) q.push_back({dev, 1'b1});
    // Bus byte i uses lane n-1-i, or lane i when the low byte goes first.
    for (i = 0; i < n; i++) begin
      ln = ord ? i : n - 1 - i;
      if (w) begin
        q.push_back(tx[8 * ln +: 8]);
      end else begin
        slv.rsp.push_back(tx[8 * ln +: 8]);
        rxm[8 * ln +: 8] = tx[8 * ln +: 8];
      end
    end
    if (dev != SLV) q = q[0:0];
    // Configuration is only touched while no operation runs.
    apb(1'b1, `OFS_MST_CFG, {8'h00, ord, 5'h00, pal, 9'h000, dev});
    apb(1'b1, `OFS_TX_DATA, tx);
    slv.got.delete();
    apb(1'b1, `OFS_MST_CTRL, {1'b1, w, 3'b000, 3'(n), 8'h00, pa});
    for (i = 0; i < 400; i++) begin
      apb(1'b0, `OFS_STATUS, 32'h0);
      if (rd[1] === 1'b1) break;
    end
    fail_wait(i, 400);
    chk({31'h0, rd[2]}, {31'h0, dev != SLV});
    apb(1'b1, `OFS_STATUS, 32'h00000006);
    chk(32'(slv.got.size()), 32'(q.size()));
    foreach (q[j]) chk({24'h0, slv.got[j]}, {24'h0, q[j]});
    if (!w) begin
      apb(1'b0, `OFS_RX_DATA, 32'h0);
      chk(rd, rxm);
    end
  endtask : run_xfer

  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, `OFS_SOFT_RESET, 32'h0);
    chk(rd, 32'h00000000);
    apb(1'b0, 20'h49200, 32'h0);
    chk({31'h0, err}, 32'h00000001);
    chk(rd, 32'h00000000);
    for (k = 0; k < 4; k++) begin
      c = rnd();
      apb(1'b1, `OFS_MST_CFG, c);
      apb(1'b0, `OFS_MST_CFG, 32'h0);
      chk(rd, c & 32'h0083007F);
    end
    $display("test config access finished");
    for (k = 0; k < 8; k++)
      run_xfer(1'b1, SLV, 2'(k >> 1), k[0], 1 + rnd() % 4);
    run_xfer(1'b1, SLV ^ 7'h01, 2'h1, 1'b0, 2);
    $display("test write transfers finished");
    for (k = 0; k < 8; k++)
      run_xfer(1'b0, SLV, 2'(k >> 1), k[0], 1 + rnd() % 4);
    $display("test read transfers finished");
    // Stop between bit two and three so the slave holds no acknowledge.
    c = {8'h00, 1'b1, 7'h02, 9'h000, SLV};
    apb(1'b1, `OFS_MST_CFG, c);
    apb(1'b1, `OFS_MST_CTRL, 32'hC4001234);
    for (k = 0; k < 2000 && !(slv.bitn == 2 && slv.got.size() > 1); k++)
      @(posedge clk);
    fail_wait(k, 2000);
    strap <= 7'h4A;
    apb(1'b1, `OFS_SOFT_RESET, 32'h80000000);
    apb(1'b0, `OFS_STATUS, 32'h0);
    chk(rd & 32'h00007F07, 32'h00003500);
    chk({30'h0, scl_oe, sda_oe}, 32'h0);
    chk({30'h0, scl_o, sda_o}, 32'h0);
    apb(1'b1, `OFS_MST_CTRL, 32'hC1000000);
    apb(1'b0, `OFS_STATUS, 32'h0);
    chk({31'h0, rd[0]}, 32'h0);
    apb(1'b0, `OFS_MST_CFG, 32'h0);
    chk(rd, c);
    apb(1'b0, `OFS_SOFT_RESET, 32'h0);
    chk(rd, 32'h80000000);
    repeat (30) @(posedge clk);
    chk({30'h0, scl_oe, sda_oe}, 32'h0);
    apb(1'b1, `OFS_SOFT_RESET, 32'h0);
    run_xfer(1'b1, SLV, 2'h2, 1'b1, 3);
    $display("test soft reset finished");
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, `OFS_MST_CFG, 32'h0);
    chk(rd, 32'h00000000);
    $display("test full reset finished");
    conclude();
  end
endmodule : i2c_soft_reset_master_config_tb
